// File: tune_pkg.sv
package tune_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WAKE_DELAY_US = 7;
  localparam int SETTLE_TIME_US = 50;
  localparam int WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
  // internal wake-up latency, well inside the wake limit
  localparam int WAKE_USE_CYC = 8;
  localparam int CNT_W = 14;
  // ------------------------------------------------------------
  // tune word layout
  // ------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int BAND_BITS = 2;
  localparam int OFFSET_BITS = 8;
  localparam int BAND_HI = 15;
  localparam int BAND_LO = 8;
  localparam int OFFSET_HI = 7;
  localparam int BITCNT_W = 5;
  localparam logic [BITCNT_W-1:0] BITCNT_RESET = 5'h00;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
endpackage : tune_pkg

// File: sync_if.sv
`timescale 1ns/100ps
interface sync_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic stb_n;
  modport src (output sclk, cs_n, mosi, stb_n);
  modport dst (input sclk, cs_n, mosi, stb_n);
endinterface : sync_if

// File: pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  input wire logic stb_n_pin,
  // filtered levels
  sync_if.src q
);
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] lvl;

  // ------------------------------------------------------------
  // three stages; a level changes once stages two and three agree
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 4'he;
      s2 <= 4'he;
      s3 <= 4'he;
    end else begin
      s1 <= {stb_n_pin, mosi_pin, cs_n_pin, sclk_pin};
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl[g] <= (g != 0) && (g != 2);
        end else if (s2[g] == s3[g]) begin
          lvl[g] <= s3[g];
        end
      end
    end
  endgenerate

  assign q.sclk = lvl[0];
  assign q.cs_n = lvl[1];
  assign q.mosi = lvl[2];
  assign q.stb_n = lvl[3];
endmodule : pin_sync

// File: filter_tune_command_port.sv
`timescale 1ns/100ps
// How it works
// - serial mode 0: clock idles low, data taken on rising edge.
// - a serial command is at least sixteen bits while chip select is low; the first sixteen are kept.
// - serial word arrives high byte first, each byte MSB first.
// - busy rises within 7 us of chip select or strobe falling.
// - tune completes within 50 us of chip select rising.
// - parallel command is ten bits at once: two band, eight offset.
// - upper band pin is band MSB, offset bit 7 is offset MSB.
// - interface select high means parallel, otherwise serial.
// - busy low when idle, high while processing, low when done.
// - first serial byte is band, second byte is offset.
// - serial mode keeps only the two low bits of the band byte.
module filter_tune_command_port (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // mode strap
  input wire logic INTERFACE_SELECT_PIN,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  // parallel port
  input wire logic PARALLEL_LOAD_STROBE_N,
  input wire logic [1:0] BAND_BITS,
  input wire logic [7:0] OFFSET_BITS,
  // status and applied tune
  output logic BUSY,
  output logic TUNE_VALID,
  output logic TUNE_STROBE,
  output logic [1:0] TUNE_BAND,
  output logic [7:0] TUNE_OFFSET,
  output logic PARALLEL_MODE
);
  typedef enum {IDLE, WAKE, SHIFT, SETTLE} state_e;

  sync_if sy ();
  state_e state;
  logic strapped;
  logic sclk_d;
  logic cs_n_d;
  logic stb_n_d;
  logic [tune_pkg::BITCNT_W-1:0] bitcnt;
  logic [tune_pkg::WORD_BITS-1:0] shreg;
  logic [tune_pkg::CNT_W-1:0] timer;
  logic [1:0] par_band;
  logic [7:0] par_offset;
  logic [9:0] dat_s1;
  logic [9:0] dat_s2;
  logic [9:0] dat_s3;
  logic [9:0] dat_lvl;
  logic start;
  logic sclk_rise;
  logic cs_rise;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  pin_sync u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .sclk_pin(SCLK),
    .cs_n_pin(CS_N),
    .mosi_pin(MOSI),
    .stb_n_pin(PARALLEL_LOAD_STROBE_N),
    .q(sy.src)
  );

  // ------------------------------------------------------------
  // mode strap, caught once after reset release
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strapped <= 1'b0;
      PARALLEL_MODE <= 1'b0;
    end else if (!strapped) begin
      strapped <= 1'b1;
      PARALLEL_MODE <= INTERFACE_SELECT_PIN;
    end
  end

  // ------------------------------------------------------------
  // edge detection on filtered levels
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      stb_n_d <= 1'b1;
    end else begin
      sclk_d <= sy.sclk;
      cs_n_d <= sy.cs_n;
      stb_n_d <= sy.stb_n;
    end
  end

  assign sclk_rise = sy.sclk && !sclk_d;
  assign cs_rise = sy.cs_n && !cs_n_d;
  assign start = strapped && (PARALLEL_MODE ? (!sy.stb_n && stb_n_d)
                                            : (!sy.cs_n && cs_n_d));

  // ------------------------------------------------------------
  // parallel data pins, three stages; a bit moves once two agree
  // ------------------------------------------------------------
  // same delay as the strobe path, so pin setup and hold carry over
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dat_s1 <= 10'h000;
      dat_s2 <= 10'h000;
      dat_s3 <= 10'h000;
    end else begin
      dat_s1 <= {BAND_BITS, OFFSET_BITS};
      dat_s2 <= dat_s1;
      dat_s3 <= dat_s2;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dat_lvl <= 10'h000;
    end else begin
      dat_lvl <= (dat_s3 & ~(dat_s2 ^ dat_s3))
                 | (dat_lvl & (dat_s2 ^ dat_s3));
    end
  end

  // ------------------------------------------------------------
  // parallel capture at strobe fall
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      par_band <= 2'h0;
      par_offset <= 8'h00;
    end else if (state == IDLE && start && PARALLEL_MODE) begin
      par_band <= dat_lvl[9:8];
      par_offset <= dat_lvl[7:0];
    end
  end

  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shreg <= tune_pkg::WORD_RESET;
      bitcnt <= tune_pkg::BITCNT_RESET;
    end else if (state == IDLE) begin
      bitcnt <= tune_pkg::BITCNT_RESET;
    end else if (state != SETTLE && !PARALLEL_MODE && !sy.cs_n
                 && sclk_rise && bitcnt < 5'h10) begin
      shreg <= {shreg[14:0], sy.mosi};
      bitcnt <= bitcnt + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= IDLE;
      timer <= '0;
      BUSY <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          // a start while busy never reaches here
          if (start) begin
            state <= WAKE;
            timer <= '0;
          end
        end
        WAKE: begin
          timer <= timer + 14'h0001;
          if (timer == 14'(tune_pkg::WAKE_USE_CYC - 1)) begin
            BUSY <= 1'b1;
            timer <= '0;
            state <= PARALLEL_MODE ? SETTLE : SHIFT;
          end
        end
        SHIFT: begin
          if (bitcnt == 5'h10 && cs_rise) begin
            state <= SETTLE;
            timer <= '0;
          end else if (cs_rise) begin
            state <= IDLE; // short frame dropped
            BUSY <= 1'b0;
          end
        end
        SETTLE: begin
          timer <= timer + 14'h0001;
          // settle counts from the chip select rise (parallel: from end of wake); half the limit
          if (timer == 14'(tune_pkg::SETTLE_CYC / 2)) begin
            state <= IDLE;
            BUSY <= 1'b0;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // applied tune
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TUNE_VALID <= 1'b0;
      TUNE_STROBE <= 1'b0;
      TUNE_BAND <= 2'h0;
      TUNE_OFFSET <= 8'h00;
    end else begin
      TUNE_STROBE <= 1'b0;
      if (state == SETTLE && timer == '0) begin
        TUNE_VALID <= 1'b1;
        TUNE_STROBE <= 1'b1;
        if (PARALLEL_MODE) begin
          TUNE_BAND <= par_band;
          TUNE_OFFSET <= par_offset;
        end else begin
          TUNE_BAND <= shreg[tune_pkg::BAND_LO+:2];
          TUNE_OFFSET <= shreg[tune_pkg::OFFSET_HI:0];
        end
      end
    end
  end
endmodule : filter_tune_command_port

// File: tune_chk.sv
`timescale 1ns/100ps
module tune_chk (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // host side
  input wire logic INTERFACE_SELECT_PIN,
  input wire logic CS_N,
  input wire logic PARALLEL_LOAD_STROBE_N,
  // status and tune
  input wire logic BUSY,
  input wire logic TUNE_VALID,
  input wire logic TUNE_STROBE,
  input wire logic [1:0] TUNE_BAND,
  input wire logic [7:0] TUNE_OFFSET,
  input wire logic PARALLEL_MODE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // cycles since reset release, saturating
  logic [1:0] age;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  // busy cycles since the command was handed over, saturating;
  // later chip select edges while busy do not restart it
  logic cs_n_q;
  logic [12:0] hold;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_n_q <= 1'b1;
      hold <= 13'h0000;
    end else begin
      cs_n_q <= CS_N;
      if (!BUSY) begin
        hold <= 13'h0000;
      end else if (hold == 13'h0000) begin
        if (PARALLEL_MODE || (CS_N && !cs_n_q)) hold <= 13'h0001;
      end else if (hold != 13'h1fff) begin
        hold <= hold + 13'h0001;
      end
    end
  end
  serial_wake_a: assert property (
    $fell(CS_N) && !PARALLEL_MODE && !BUSY && age == 2'h3
    |-> ##[1:700] BUSY) else $error("late busy after cs");
  par_wake_a: assert property (
    $fell(PARALLEL_LOAD_STROBE_N) && PARALLEL_MODE && !BUSY && age == 2'h3
    |-> ##[1:700] BUSY) else $error("late busy after strobe");
  serial_settle_a: assert property (
    !PARALLEL_MODE && hold != 13'h0000
    |-> hold <= 13'(tune_pkg::SETTLE_CYC))
    else $error("serial tune too long");
  par_settle_a: assert property (
    PARALLEL_MODE && hold != 13'h0000
    |-> hold <= 13'(tune_pkg::SETTLE_CYC))
    else $error("parallel tune too long");
  apply_busy_a: assert property (TUNE_STROBE |-> BUSY)
    else $error("tune applied while idle");
  valid_after_a: assert property (TUNE_STROBE |=> TUNE_VALID)
    else $error("valid missing after tune");
  tune_hold_a: assert property ($changed({TUNE_BAND, TUNE_OFFSET})
    |-> TUNE_STROBE || $past(TUNE_STROBE)) else $error("tune moved alone");
  mode_hold_a: assert property (
    age == 2'h3 |-> $stable(PARALLEL_MODE))
    else $error("mode changed after start");
  mode_pick_a: assert property (age == 2'h2
    |-> PARALLEL_MODE == INTERFACE_SELECT_PIN) else $error("wrong mode");
  cover property ($fell(BUSY) && PARALLEL_MODE);
  cover property ($fell(BUSY) && !PARALLEL_MODE);
  cover property (TUNE_STROBE);
endmodule : tune_chk
bind filter_tune_command_port tune_chk chk_u (.SYS_CLK(SYS_CLK),
  .RST_N(RST_N), .INTERFACE_SELECT_PIN(INTERFACE_SELECT_PIN), .CS_N(CS_N),
  .PARALLEL_LOAD_STROBE_N(PARALLEL_LOAD_STROBE_N), .BUSY(BUSY),
  .TUNE_VALID(TUNE_VALID), .TUNE_STROBE(TUNE_STROBE),
  .TUNE_BAND(TUNE_BAND), .TUNE_OFFSET(TUNE_OFFSET),
  .PARALLEL_MODE(PARALLEL_MODE));

// File: host_model.sv
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  // parallel port
  output logic stb_n,
  output logic [1:0] band,
  output logic [7:0] offset
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    stb_n = 1'b1;
    band = 2'h0;
    offset = 8'h00;
  end
  task automatic send_serial(input logic [1:0] b, input logic [7:0] o);
    logic [15:0] word;
    word = {6'h00, b, o};
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      mosi <= word[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (10) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~word[0];
    // keep chip select high long enough to pass the pin filter
    repeat (10) @(posedge clk);
  endtask : send_serial
  task automatic send_par(input logic [1:0] b, input logic [7:0] o);
    @(posedge clk);
    band <= b;
    offset <= o;
    repeat (10) @(posedge clk);
    stb_n <= 1'b0;
    repeat (10) @(posedge clk);
    stb_n <= 1'b1;
    band <= ~b;
    offset <= ~o;
  endtask : send_par
endmodule : host_model

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic sclk, cs_n, mosi, stb_n, busy, t_valid, t_stb, p_mode;
  logic [1:0] band, t_band;
  logic [7:0] offset, t_off;
  int errors = 0;
  int n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  host_model host_u (.clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .stb_n(stb_n), .band(band), .offset(offset));
  filter_tune_command_port dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .INTERFACE_SELECT_PIN(sel), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
    .PARALLEL_LOAD_STROBE_N(stb_n), .BAND_BITS(band), .OFFSET_BITS(offset),
    .BUSY(busy), .TUNE_VALID(t_valid), .TUNE_STROBE(t_stb),
    .TUNE_BAND(t_band), .TUNE_OFFSET(t_off), .PARALLEL_MODE(p_mode));
  task check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task stop_test;
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task wait_busy(input logic lvl, input int lim);
    for (int i = 0; i < lim && busy !== lvl; i++) @(negedge sys_clk);
    check("busy", {9'h0, lvl}, {9'h0, busy});
    if (busy !== lvl) stop_test();
  endtask : wait_busy
  task do_reset(input logic mode);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    sel <= mode;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check("idle status", 10'h0, {8'h0, busy, t_valid});
    check("mode", {9'h0, mode}, {9'h0, p_mode});
  endtask : do_reset
  task t_serial;
    fork
      host_u.send_serial(2'h1, 8'hA5);
      wait_busy(1'b1, 700);
    join
    wait_busy(1'b0, 5000);
    check("serial tune", 10'h1A5, {t_band, t_off});
    check("tune valid", 10'h1, {9'h0, t_valid});
    $display("test serial done");
  endtask : t_serial
  task t_ignore;
    fork
      host_u.send_serial(2'h2, 8'h3C);
      wait_busy(1'b1, 700);
    join
    host_u.send_serial(2'h3, 8'hFF);
    wait_busy(1'b0, 5000);
    repeat (20) @(negedge sys_clk);
    check("busy after ignored", 10'h0, {9'h0, busy});
    check("kept tune", 10'h23C, {t_band, t_off});
    $display("test ignore done");
  endtask : t_ignore
  task t_parallel;
    do_reset(1'b1);
    fork
      host_u.send_par(2'h2, 8'h5A);
      wait_busy(1'b1, 700);
    join
    wait_busy(1'b0, 5000);
    check("parallel tune", 10'h25A, {t_band, t_off});
    sel <= 1'b0;
    repeat (300) @(posedge sys_clk);
    host_u.send_par(2'h1, 8'h81);
    wait_busy(1'b1, 700);
    wait_busy(1'b0, 5000);
    check("mode kept", 10'h181, {t_band, t_off});
    check("mode pin", 10'h1, {9'h0, p_mode});
    $display("test parallel done");
  endtask : t_parallel
  initial begin
    do_reset(1'b0);
    t_serial();
    repeat (300) @(posedge sys_clk);
    t_ignore();
    t_parallel();
    stop_test();
  end
endmodule : testbench
